// ===== hdl/smp_pkg.sv
// shared constants and types for the synchronous memory port with bus surrender
package smp_pkg;

   // ---------------------------------------------------------------
   // widths of the memory bus
   // ---------------------------------------------------------------
   localparam int DW  = 16;                     // ext_data lines
   localparam int AW  = 20;                     // ext_address lines 21..2
   localparam int CSN = 4;                      // chip selects
   localparam int BLN = 2;                      // byte lanes

   // ---------------------------------------------------------------
   // burst and latency figures, in memory clock edges
   // ---------------------------------------------------------------
   localparam int         BURST_LEN  = 4;                    // words per default burst
   localparam logic [1:0] BURST_REST = 2'(BURST_LEN - 1);    // words after the first
   localparam int         SD_CAS_LAT = 3;                    // sdram read latency
   localparam int         SR_RD_LAT  = 2;                    // sram pipelined read latency
   localparam int         PIPE_W     = SD_CAS_LAT + 1;
   localparam int         SD_ALLBANK_BIT = 10;               // address bit that selects all banks

   // ---------------------------------------------------------------
   // surrender timing, in memory input clock periods (E)
   // ---------------------------------------------------------------
   localparam int         FLOAT_MIN_E  = 2;
   localparam int         GRANT_MAX_E  = 2;
   localparam int         RESUME_MIN_E = 2;
   localparam int         RESUME_MAX_E = 7;
   // one extra edge covers the unknown phase of the synchronised request
   localparam logic [2:0] FLOAT_EDGES  = 3'(FLOAT_MIN_E + 1);
   localparam logic [2:0] RESUME_EDGES = 3'(RESUME_MIN_E + 1);

   // ---------------------------------------------------------------
   // shared strobe pins: bit positions and sdram commands {we,ras,cas}
   // ---------------------------------------------------------------
   localparam int         STB_AC = 0;                        // addr strobe / column strobe
   localparam int         STB_OR = 1;                        // output enable / row strobe
   localparam int         STB_WE = 2;                        // write enable
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_ACT = 3'h5;
   localparam logic [2:0] CMD_PRE = 3'h1;
   localparam logic [2:0] CMD_REF = 3'h4;
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_RD  = 3'h6;
   localparam logic [2:0] CMD_WR  = 3'h2;

   // ---------------------------------------------------------------
   // values after reset and buffer depth
   // ---------------------------------------------------------------
   localparam logic [CSN-1:0] RST_CE_N   = 4'hf;
   localparam logic [BLN-1:0] RST_BLS_N  = 2'h3;
   localparam logic           RST_BUS_OE = 1'h1;
   localparam int             FIFO_DEPTH = 8;

   // request operations
   typedef enum logic [2:0] {
      OP_READ = 3'h0, OP_WRITE = 3'h1, OP_ROW_OPEN = 3'h2, OP_CLOSE_ROW = 3'h3,
      OP_CLOSE_ALL = 3'h4, OP_RESTORE = 3'h5, OP_MODE_SETUP = 3'h6
   } smp_op_t;

   // bus ownership states, gray from ST_OWN to ST_DRIVE; the step from ST_DRIVE back to ST_OWN flips all three bits
   typedef enum logic [2:0] {
      ST_OWN = 3'h0, ST_DRAIN = 3'h1, ST_FLOAT = 3'h3,
      ST_HELD = 3'h2, ST_RESUME = 3'h6, ST_DRIVE = 3'h7
   } smp_bus_t;

   // one buffered request
   typedef struct packed {
      smp_op_t        op;
      logic           sd;
      logic [1:0]     cs;
      logic [BLN-1:0] be;
      logic [AW-1:0]  addr;
      logic [DW-1:0]  data;
   } smp_req_t;

endpackage

// ===== hdl/smp_fifo.sv
// request buffer with valid and ready on both sides
`timescale 1ns/100ps
module smp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   // system
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wp;
      logic [PW-1:0]           rp;
      logic [PW:0]             cnt;
      logic                    rdy;
      logic                    vld;
   } smp_fifo_st_t;

   smp_fifo_st_t r_ff;
   smp_fifo_st_t nxt_r;
   logic         push;
   logic         pop;

   // ---------------------------------------------------------------
   // pointers and fill level
   // ---------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      push  = in_valid && r_ff.rdy;
      pop   = out_ready && r_ff.vld;
      if (push) begin
         nxt_r.mem[r_ff.wp] = in_data;
         nxt_r.wp = (r_ff.wp == PW'(DEPTH - 1)) ? '0 : r_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_r.rp = (r_ff.rp == PW'(DEPTH - 1)) ? '0 : r_ff.rp + 1'b1;
      end
      nxt_r.cnt = r_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
      // flags registered so both sides see clean levels
      nxt_r.rdy = nxt_r.cnt != (PW+1)'(DEPTH);
      nxt_r.vld = nxt_r.cnt != '0;
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_ff     <= '0;
         r_ff.rdy <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign in_ready  = r_ff.rdy;
   assign out_valid = r_ff.vld;
   assign out_data  = r_ff.mem[r_ff.rp];

endmodule

// ===== hdl/smp_port.sv
// synchronous memory port: burst sram and sdram cycles plus bus surrender
//
// How it works
// - sram uses memory burst counter, four-word bursts
// - sdram uses memory burst counter, four-word bursts
// - odd orders made by cutting bursts short
// - every burst type keeps data flowing
// - sram strobes: address strobe, output enable, write
// - sdram strobes: column strobe, write, row strobe
// - sdram read data taken three clocks later
// - surrender floats selects, lanes, data, address, strobes
// - in-flight transfers finish before the grant
// - idle bus is granted with least delay
// - inhibit set means surrender requests are ignored
// - bus floats no sooner than two periods
// - grant falls within two periods of floating
// - bus driven again two to seven periods
// - grant rises within two periods of driving
`timescale 1ns/100ps
module smp_port
   import smp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // system
   input  wire logic           clk_sys,
   input  wire logic           rst,
   // request stream
   input  wire logic           req_valid,
   output logic                req_ready,
   input  wire logic [2:0]     req_op,
   input  wire logic           req_sdram,
   input  wire logic [1:0]     req_cs,
   input  wire logic [BLN-1:0] req_be,
   input  wire logic [AW-1:0]  req_addr,
   input  wire logic [DW-1:0]  req_wdata,
   // read return
   output logic                rd_valid,
   output logic [DW-1:0]       rd_data,
   // configuration
   input  wire logic           surrender_inhibit,
   // memory clock
   input  wire logic           memclk_in,
   output logic                memclk_out,
   // memory bus
   output logic [CSN-1:0]      ce_n,
   output logic [BLN-1:0]      byte_lane_strobe_n,
   output logic [AW-1:0]       ext_address,
   output logic [2:0]          shared_stb_n,
   output logic                bus_oe,
   input  wire logic [DW-1:0]  ext_data_in,
   output logic [DW-1:0]       ext_data_out,
   output logic                ext_data_oe,
   // bus surrender
   input  wire logic           hold_req_n,
   output logic                bus_surrender_grant_n
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              m1, m2, mclk, rise;
      logic              h1, h2;
      logic [DW-1:0]     d1, d2;
      smp_bus_t          st;
      logic [2:0]        ecnt;
      logic [1:0]        bcnt;
      logic [AW-1:0]     bnext;
      logic              bsd, bwr;
      logic [1:0]        bcs;
      logic [PIPE_W-1:0] pipe;
      logic [CSN-1:0]    ce_n;
      logic [BLN-1:0]    bls_n;
      logic [AW-1:0]     addr;
      logic [2:0]        stb_n;
      logic              bus_oe;
      logic [DW-1:0]     dout;
      logic              dout_oe;
      logic              grant_n;
      logic              rd_valid;
      logic [DW-1:0]     rd_data;
   } smp_state_t;

   smp_state_t        r_ff;
   smp_state_t        nxt_r;
   smp_req_t          e;
   logic [$bits(smp_req_t)-1:0] f_data;
   logic              f_valid;
   logic              f_ready;
   logic              hold_ask;
   logic              is_rw;
   logic              is_rd;
   logic              cont;
   logic              clash;
   logic              can_issue;
   logic [PIPE_W-1:0] sh;
   logic [PIPE_W-1:0] slot;

   // ---------------------------------------------------------------
   // request buffer
   // ---------------------------------------------------------------
   smp_fifo #(
      .W     ($bits(smp_req_t)),
      .DEPTH (DEPTH)
   ) smp_fifo_i (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   ({req_op, req_sdram, req_cs, req_be, req_addr, req_wdata}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   assign e = smp_req_t'(f_data);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      // two-flop synchronisers for clock, request and read data
      nxt_r.m1 = memclk_in;
      nxt_r.m2 = r_ff.m1;
      nxt_r.mclk = r_ff.m2;
      nxt_r.h1 = hold_req_n;
      nxt_r.h2 = r_ff.h1;
      nxt_r.d1 = ext_data_in;
      nxt_r.d2 = r_ff.d1;
      // act one cycle after memclk_out rises, so pins never race it
      nxt_r.rise = r_ff.m2 & ~r_ff.mclk;
      nxt_r.rd_valid = 1'b0;
      hold_ask = ~r_ff.h2 & ~surrender_inhibit;
      is_rw = (e.op == OP_READ) || (e.op == OP_WRITE);
      is_rd = e.op == OP_READ;
      sh = r_ff.pipe >> 1;
      slot = e.sd ? PIPE_W'(1 << SD_CAS_LAT) : PIPE_W'(1 << SR_RD_LAT);
      // words following the open burst ride the memory's own counter
      cont = (r_ff.bcnt != 2'h0) && is_rw && (e.sd == r_ff.bsd) &&
             ((e.op == OP_WRITE) == r_ff.bwr) && (e.cs == r_ff.bcs) &&
             (e.addr == r_ff.bnext);
      // reads in flight block a change of memory or direction (turnaround)
      clash = (r_ff.pipe != '0) && ((e.sd != r_ff.bsd) || !is_rd);
      can_issue = r_ff.rise && (r_ff.st == ST_OWN) && !hold_ask && f_valid && !clash;
      f_ready = can_issue;

      // memory clock edge: capture, shift, default to idle pins
      if (r_ff.rise) begin
         if (r_ff.pipe[0]) begin
            nxt_r.rd_valid = 1'b1;
            nxt_r.rd_data = r_ff.d2;
         end
         nxt_r.pipe = sh;
         nxt_r.ce_n = RST_CE_N;
         nxt_r.stb_n = CMD_NOP;
         nxt_r.bls_n = RST_BLS_N; // masks any tail of an abandoned write burst
         nxt_r.dout_oe = 1'b0;
         if (r_ff.bcnt != 2'h0 && !can_issue) begin
            nxt_r.bcnt = 2'h0;
         end
         // sram keeps its output enable low while its reads drain
         if (!r_ff.bsd && sh != '0) begin
            nxt_r.stb_n[STB_OR] = 1'b0;
         end
      end

      // issue one request word
      if (can_issue) begin
         nxt_r.ce_n = ~(CSN'(1) << e.cs);
         nxt_r.addr = e.addr;
         if (is_rw) begin
            // a new address cuts the burst and starts another at once
            nxt_r.bcnt = cont ? r_ff.bcnt - 2'h1 : BURST_REST;
            nxt_r.bnext = e.addr + AW'(1);
            nxt_r.bsd = e.sd;
            nxt_r.bwr = !is_rd;
            nxt_r.bcs = e.cs;
            nxt_r.bls_n = is_rd ? '0 : ~e.be;
            nxt_r.dout = e.data;
            nxt_r.dout_oe = !is_rd;
            if (is_rd) begin
               nxt_r.pipe = sh | slot;
            end
            if (e.sd) begin
               nxt_r.stb_n = cont ? CMD_NOP : (is_rd ? CMD_RD : CMD_WR);
            end else begin
               nxt_r.stb_n[STB_AC] = cont;
               nxt_r.stb_n[STB_OR] = !is_rd;
               nxt_r.stb_n[STB_WE] = is_rd;
            end
         end else begin
            nxt_r.bcnt = 2'h0;
            nxt_r.bsd = 1'b1;
            // remaining sdram commands
            case (e.op)
               OP_ROW_OPEN:   nxt_r.stb_n = CMD_ACT;
               OP_CLOSE_ROW: begin
                  nxt_r.stb_n = CMD_PRE;
                  nxt_r.addr[SD_ALLBANK_BIT] = 1'b0;
               end
               OP_CLOSE_ALL: begin
                  nxt_r.stb_n = CMD_PRE;
                  nxt_r.addr[SD_ALLBANK_BIT] = 1'b1;
               end
               OP_RESTORE:    nxt_r.stb_n = CMD_REF;
               OP_MODE_SETUP: nxt_r.stb_n = CMD_MRS;
               default:       nxt_r.stb_n = CMD_NOP;
            endcase
         end
      end

      // bus surrender, counted in memory clock edges
      case (r_ff.st)
         ST_OWN: begin
            if (hold_ask) begin
               nxt_r.st = ST_DRAIN;
               nxt_r.ecnt = 3'h0;
            end
         end
         ST_DRAIN: begin
            if (r_ff.h2) begin
               nxt_r.st = ST_OWN;
            end else if (r_ff.rise) begin
               if (r_ff.ecnt < FLOAT_EDGES - 3'h1) begin
                  nxt_r.ecnt = r_ff.ecnt + 3'h1;
               end else if (sh == '0) begin
                  // idle bus floats on the first legal edge
                  nxt_r.st = ST_FLOAT;
                  nxt_r.bus_oe = 1'b0;
                  nxt_r.dout_oe = 1'b0;
                  nxt_r.bcnt = 2'h0;
               end
            end
         end
         ST_FLOAT: begin
            if (r_ff.rise) begin
               nxt_r.st = ST_HELD;
               nxt_r.grant_n = 1'b0;
            end
         end
         ST_HELD: begin
            // the master keeps the request low past the grant, so no glitch
            if (r_ff.h2) begin
               nxt_r.st = ST_RESUME;
               nxt_r.ecnt = 3'h0;
            end
         end
         ST_RESUME: begin
            if (r_ff.rise) begin
               if (r_ff.ecnt < RESUME_EDGES - 3'h1) begin
                  nxt_r.ecnt = r_ff.ecnt + 3'h1;
               end else begin
                  nxt_r.st = ST_DRIVE;
                  nxt_r.bus_oe = 1'b1;
               end
            end
         end
         ST_DRIVE: begin
            if (r_ff.rise) begin
               nxt_r.st = ST_OWN;
               nxt_r.grant_n = 1'b1;
            end
         end
         default: nxt_r.st = ST_OWN;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_ff         <= '0;
         r_ff.h1      <= 1'b1;
         r_ff.h2      <= 1'b1;
         r_ff.ce_n    <= RST_CE_N;
         r_ff.bls_n   <= RST_BLS_N;
         r_ff.stb_n   <= CMD_NOP;
         r_ff.bus_oe  <= RST_BUS_OE;
         r_ff.grant_n <= 1'b1;
         r_ff.st      <= ST_OWN;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign memclk_out            = r_ff.mclk;
   assign ce_n                  = r_ff.ce_n;
   assign byte_lane_strobe_n    = r_ff.bls_n;
   assign ext_address           = r_ff.addr;
   assign shared_stb_n          = r_ff.stb_n;
   assign bus_oe                = r_ff.bus_oe;
   assign ext_data_out          = r_ff.dout;
   assign ext_data_oe           = r_ff.dout_oe;
   assign bus_surrender_grant_n = r_ff.grant_n;
   assign rd_valid              = r_ff.rd_valid;
   assign rd_data               = r_ff.rd_data;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [3:0] low_e_ff;
   logic [3:0] high_e_ff;
   logic       sd_rd_cmd;

   // memory edges seen since the request went low or high
   always_ff @(posedge clk_sys) begin
      if (rst || r_ff.h2) low_e_ff <= 4'h0;
      else if (r_ff.rise && low_e_ff != 4'hf) low_e_ff <= low_e_ff + 4'h1;
      if (rst || !r_ff.h2) high_e_ff <= 4'h0;
      else if (r_ff.rise && high_e_ff != 4'hf) high_e_ff <= high_e_ff + 4'h1;
   end

   assign sd_rd_cmd = r_ff.bsd && r_ff.stb_n == CMD_RD && r_ff.ce_n != RST_CE_N;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_burst_start: assert property (can_issue && is_rw && r_ff.bcnt == 2'h0
      |=> !r_ff.stb_n[STB_AC]) else $error("burst start without strobe");
   a_burst_flow: assert property (can_issue && cont
      |=> r_ff.stb_n[STB_AC] && !r_ff.ce_n[$past(e.cs)]) else $error("continued word restrobed");
   a_sram_read_oe: assert property ($past(r_ff.rise) && r_ff.bus_oe && !r_ff.bsd
      && !r_ff.stb_n[STB_AC] && r_ff.stb_n[STB_WE] |-> !r_ff.stb_n[STB_OR] ##1
      !r_ff.stb_n[STB_OR]) else $error("sram read without output enable");
   a_sd_read_lat: assert property ($past(r_ff.rise) && sd_rd_cmd
      |-> ##[24:40] r_ff.rd_valid) else $error("sdram read data not taken");
   a_held_float: assert property (r_ff.st == ST_HELD
      |-> !r_ff.bus_oe && !r_ff.dout_oe) else $error("bus driven while surrendered");
   a_drain_done: assert property ($fell(r_ff.bus_oe)
      |-> r_ff.pipe == '0) else $error("floated with reads in flight");
   a_inhibit_keep: assert property (surrender_inhibit && r_ff.st == ST_OWN
      |=> r_ff.st == ST_OWN) else $error("surrender despite inhibit");
   a_float_delay: assert property ($fell(r_ff.bus_oe)
      |-> low_e_ff >= 4'(FLOAT_EDGES)) else $error("bus floated too early");
   a_grant_after: assert property ($fell(r_ff.bus_oe)
      |-> r_ff.grant_n ##[1:16] !r_ff.grant_n) else $error("grant late");
   a_resume_window: assert property ($rose(r_ff.bus_oe) |->
      high_e_ff >= 4'(RESUME_EDGES) && high_e_ff <= 4'(RESUME_MAX_E))
      else $error("bus resumed outside window");
   a_grant_release: assert property ($rose(r_ff.bus_oe)
      |-> !r_ff.grant_n ##[1:16] r_ff.grant_n) else $error("grant not released");
   a_edge_aligned: assert property ($changed(r_ff.addr) || $changed(r_ff.stb_n)
      |-> $past(r_ff.rise)) else $error("pin changed off the clock edge");

   c_surrender: cover property ($fell(r_ff.grant_n));
   c_sd_read: cover property (r_ff.rd_valid && r_ff.bsd);
   c_burst_cont: cover property (can_issue && cont);
   c_burst_cut: cover property (can_issue && is_rw && !cont && r_ff.bcnt != 2'h0);

endmodule

// ===== bench/smp_mem_model.sv
// memory model: burst sram on chip select 0, sdram on the others
`timescale 1ns/100ps
module smp_mem_model
   import smp_pkg::*;
(
   // memory pins
   input  wire logic           memclk_out,
   input  wire logic [CSN-1:0] ce_n,
   input  wire logic [AW-1:0]  ext_address,
   input  wire logic [2:0]     shared_stb_n,
   input  wire logic           bus_oe,
   output logic [DW-1:0]       ext_data_in = 16'h0000
);
   logic [DW:0]   pipe [3] = '{default: '0};
   logic [AW-1:0] addr = 20'h00000;
   logic          rd_on = 1'b0;
   // ----------
   // read pipe: sdram word out two edges on, sram one edge
   // ----------
   always @(posedge memclk_out) begin
      logic sram;
      logic hit;
      sram = !ce_n[0];
      hit = 1'b1;
      if (bus_oe && ce_n != RST_CE_N && shared_stb_n == (sram ? 3'h4 : CMD_RD)) begin
         addr = ext_address;
         rd_on = 1'b1;
      end else if (bus_oe && ce_n != RST_CE_N && rd_on
                   && shared_stb_n == (sram ? 3'h5 : CMD_NOP))
         addr = addr + 20'h00001;
      else begin
         hit = 1'b0;
         rd_on = 1'b0;
      end
      pipe[0] = pipe[1];
      pipe[1] = (hit && sram) ? {1'b1, addr[15:0] ^ 16'ha5c3} : pipe[2];
      pipe[2] = (hit && !sram) ? {1'b1, addr[15:0] ^ 16'ha5c3} : 17'h00000;
      // idle data lines toggle so a stale word can never pass
      ext_data_in = pipe[0][DW] ? pipe[0][DW-1:0] : ~ext_data_in;
   end
endmodule

// ===== bench/smp_port_tb.sv
// self-checking testbench for the synchronous memory port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 4000) begin @(negedge clk_sys); n++; end \
   if (n >= 4000) begin n_mismatch++; final_report(); end end
module smp_port_tb
   import smp_pkg::*;
;
   logic           clk_sys = 1'b0;
   logic           rst = 1'b1;
   logic           memclk_in = 1'b0;
   logic           req_valid = 1'b0;
   logic [2:0]     req_op = 3'h0;
   logic           req_sdram = 1'b0;
   logic [1:0]     req_cs = 2'h0;
   logic [AW-1:0]  req_addr = 20'h00000;
   logic [DW-1:0]  req_wdata = 16'h0000;
   logic           inhibit = 1'b0;
   logic           hold_n = 1'b1;
   logic           req_ready, rd_valid, memclk_out, bus_oe, data_oe, grant_n;
   logic [DW-1:0]  rd_data, din, dout;
   logic [CSN-1:0] ce_n;
   logic [BLN-1:0] bls_n;
   logic [AW-1:0]  ea;
   logic [2:0]     stb_n, last_cmd;
   logic [DW-1:0]  exp_q [$];
   logic [DW-1:0]  exp_w;
   logic           last_a10;
   logic [2:0]     cmd_exp [5] = '{CMD_ACT, CMD_PRE, CMD_PRE, CMD_REF, CMD_MRS};
   int             n_mismatch = 0, cmp_count = 0, n_start = 0, n_word = 0, n_rdv = 0;
   int             n_wdat = 0;
   realtime        t0, tf, tg;

   always #12.5 clk_sys = ~clk_sys;
   // memory clock phase kept clear of system clock edges
   initial begin
      #33;
      forever #100 memclk_in = ~memclk_in;
   end

   smp_port smp_port_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_sdram(req_sdram), .req_cs(req_cs),
      .req_be(2'h3), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
      .rd_data(rd_data), .surrender_inhibit(inhibit), .memclk_in(memclk_in),
      .memclk_out(memclk_out), .ce_n(ce_n), .byte_lane_strobe_n(bls_n),
      .ext_address(ea), .shared_stb_n(stb_n), .bus_oe(bus_oe), .ext_data_in(din),
      .ext_data_out(dout), .ext_data_oe(data_oe), .hold_req_n(hold_n),
      .bus_surrender_grant_n(grant_n));
   smp_mem_model smp_mem_model_i (.memclk_out(memclk_out), .ce_n(ce_n),
      .ext_address(ea), .shared_stb_n(stb_n), .bus_oe(bus_oe), .ext_data_in(din));

   // ----------
   // monitors: words on the bus and returned reads
   // ----------
   always @(posedge memclk_out)
      if (bus_oe === 1'b1 && ce_n !== RST_CE_N) begin
         n_word++;
         last_cmd = stb_n;
         if (stb_n[STB_AC] === 1'b0)
            n_start++;
         // write words must carry their own data on every lane
         if (data_oe === 1'b1 && dout === ~ea[15:0] && bls_n === 2'h0)
            n_wdat++;
         last_a10 = ea[SD_ALLBANK_BIT];
      end
   // pop once, so a mismatch report cannot eat the next expected word
   always @(negedge clk_sys)
      if (rd_valid === 1'b1) begin
         n_rdv++;
         exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
         `CHK("read data", exp_w, rd_data)
      end

   task automatic push(input logic [2:0] op, input logic [1:0] cs, input logic [AW-1:0] a);
      int n;
      req_valid = 1'b1;
      req_op = op;
      req_sdram = (cs != 2'h0);
      req_cs = cs;
      req_addr = a;
      req_wdata = ~a[15:0];
      if (op == OP_READ)
         exp_q.push_back(a[15:0] ^ 16'ha5c3);
      `WAIT(req_ready === 1'b1)
      @(negedge clk_sys);
   endtask

   task automatic idle(input string nm);
      int n;
      req_valid = 1'b0;
      `WAIT(exp_q.size() == 0)
      // writes leave no trace in the queue: allow the whole burst onto the pins
      repeat (80) @(negedge clk_sys);
      $display("test %s done", nm);
   endtask

   task automatic clr;
      n_start = 0;
      n_word = 0;
      n_rdv = 0;
      n_wdat = 0;
   endtask

   // ----------
   // scenarios
   // ----------
   task automatic t_reset;
      `CHK("ce_n", RST_CE_N, ce_n)
      `CHK("stb", CMD_NOP, stb_n)
      `CHK("bus_oe", RST_BUS_OE, bus_oe)
      `CHK("grant", 1'b1, grant_n)
      $display("test reset done");
   endtask

   // five sdram writes: burst of four, then a fresh burst
   task automatic t_bursts;
      clr();
      for (int i = 0; i < 5; i++)
         push(OP_WRITE, 2'h1, 20'h00040 + 20'(i));
      idle("write burst");
      `CHK("wr starts", 2, n_start)
      `CHK("wr words", 5, n_word)
      `CHK("wr data", 5, n_wdat)
      // incrementing, jump, then decrementing reads
      clr();
      for (int i = 0; i < 4; i++)
         push(OP_READ, 2'h1, 20'h00080 + 20'(i));
      push(OP_READ, 2'h1, 20'h00090);
      push(OP_READ, 2'h1, 20'h0008f);
      push(OP_READ, 2'h1, 20'h0008e);
      idle("read orders");
      `CHK("rd starts", 4, n_start)
      `CHK("rd words", 7, n_word)
      `CHK("rd undriven", 0, n_wdat)
      clr();
      for (int i = 0; i < 4; i++)
         push(OP_READ, 2'h0, 20'h00020 + 20'(i));
      idle("sram burst");
      `CHK("sram starts", 1, n_start)
      `CHK("sram strobes", 3'h5, last_cmd)
   endtask

   task automatic t_cmds;
      for (int i = 0; i < 5; i++) begin
         push(3'(i + 2), 2'h2, 20'h00000);
         idle("sdram command");
         `CHK("command", cmd_exp[i], last_cmd)
         if (i == 1 || i == 2)
            `CHK("all banks", (i == 2), last_a10)
      end
   endtask

   task automatic t_hold(input int pend);
      int n;
      clr();
      for (int i = 0; i < pend; i++)
         push(OP_READ, 2'h1, 20'h00100 + 20'(i));
      req_valid = 1'b0;
      `WAIT(n_word > 0 || pend == 0)
      hold_n = 1'b0;
      t0 = $realtime;
      `WAIT(bus_oe === 1'b0)
      tf = $realtime;
      `WAIT(grant_n === 1'b0)
      tg = $realtime;
      `CHK("data float", 1'b0, data_oe)
      `CHK("drained", n_word, n_rdv)
      `CHK("float delay", 1'b1, (tf - t0 >= 400.0))
      `CHK("grant delay", 1'b1, (tg - tf <= 400.0))
      if (pend == 0)
         `CHK("idle grant", 1'b1, (tg - t0 <= 1200.0))
      repeat (8) @(negedge clk_sys);
      hold_n = 1'b1;
      t0 = $realtime;
      `WAIT(bus_oe === 1'b1)
      tf = $realtime;
      `WAIT(grant_n === 1'b1)
      tg = $realtime;
      `CHK("resume", 1'b1, (tf - t0 >= 400.0 && tf - t0 <= 1400.0))
      `CHK("release", 1'b1, (tg - tf <= 400.0))
      idle("surrender");
   endtask

   task automatic t_inhibit;
      logic kept;
      kept = 1'b1;
      inhibit = 1'b1;
      hold_n = 1'b0;
      repeat (80) begin
         @(negedge clk_sys);
         kept = kept & (grant_n === 1'b1) & (bus_oe === 1'b1);
      end
      `CHK("inhibit", 1'b1, kept)
      hold_n = 1'b1;
      repeat (20) @(negedge clk_sys);
      inhibit = 1'b0;
      $display("test inhibit done");
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      t_reset();
      t_bursts();
      t_cmds();
      t_hold(0);
      t_hold(4);
      t_inhibit();
      final_report();
   end
endmodule
